// *** rtl/ulm_fifo.sv ***
// flip-flop fifo of FIFO_DEPTH entries, combinational head
// assumes pushes when full and pops when empty are filtered by the caller or dropped here
`timescale 1ns/1ps
module ulm_fifo #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic           clk_in,
	input  wire logic           srst_in,
	// fill side
	input  wire logic           push_in,
	input  wire logic [W-1:0]   push_data_in,
	// drain side
	input  wire logic           pop_in,
	output logic      [W-1:0]   head_out,
	output logic                empty_out,
	output logic                full_out
);
	import ulm_pkg::*;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][W-1:0] mem;
		logic [PTR_W-1:0]             wr;
		logic [PTR_W-1:0]             rd;
		logic [CNT_W-1:0]             cnt;
	} ulm_fifo_st_t;

	ulm_fifo_st_t s_q;
	ulm_fifo_st_t s_d;
	logic         do_push;
	logic         do_pop;

	always_comb begin
		s_d     = s_q;
		do_push = push_in && (s_q.cnt != CNT_W'(FIFO_DEPTH));
		do_pop  = pop_in && (s_q.cnt != '0);
		if (do_push) begin
			s_d.mem[s_q.wr] = push_data_in;
			s_d.wr          = s_q.wr + 1'b1;
		end
		if (do_pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign head_out  = s_q.mem[s_q.rd];
	assign empty_out = (s_q.cnt == '0);
	assign full_out  = (s_q.cnt == CNT_W'(FIFO_DEPTH));

endmodule : ulm_fifo

// *** rtl/ulm_pkg.sv ***
// line status and modem control package: offsets, field positions, reset values, carriers
// assumes a 32-bit classic wishbone slave with byte addresses and registers in lane 0
package ulm_pkg;

	// fifo geometry
	localparam int unsigned FIFO_DEPTH = 64;
	localparam int unsigned PTR_W      = 6;
	localparam int unsigned CNT_W      = 7;

	// register byte offsets
	localparam logic [7:0] OFS_HOLDING      = 8'h00;
	localparam logic [7:0] OFS_LINE_STATUS  = 8'h04;
	localparam logic [7:0] OFS_MODEM_CTRL   = 8'h08;
	localparam logic [7:0] OFS_ENH_FEATURE  = 8'h0C;
	localparam logic [7:0] OFS_MODEM_STATUS = 8'h10;
	localparam logic [7:0] OFS_FLOW_THRESH  = 8'h14;
	localparam logic [7:0] OFS_TRIG_LEVEL   = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h20;

	// line status fields
	localparam int unsigned LS_FIFO_ERR   = 7;
	localparam int unsigned LS_TX_EMPTY   = 6;
	localparam int unsigned LS_HOLD_EMPTY = 5;
	localparam int unsigned LS_BREAK      = 4;
	localparam int unsigned LS_FRAME      = 3;
	localparam int unsigned LS_PARITY     = 2;
	localparam int unsigned LS_OVERRUN    = 1;
	localparam int unsigned LS_DATA_READY = 0;

	// modem control fields
	localparam int unsigned MC_CLK_DIV4  = 7;
	localparam int unsigned MC_THRESH_EN = 6;
	localparam int unsigned MC_XON_ANY   = 5;
	localparam int unsigned MC_LOOP      = 4;
	localparam int unsigned MC_OUT2      = 3;
	localparam int unsigned MC_OUT1      = 2;
	localparam int unsigned MC_RTS       = 1;
	localparam int unsigned MC_DTR       = 0;
	localparam logic [7:0]  MC_PROT_MASK = 8'hE0;

	// enhanced feature write enable
	localparam int unsigned EF_WRITE_EN = 4;

	// interrupt event bits
	localparam int unsigned IRQ_RX_DATA  = 0;
	localparam int unsigned IRQ_OVERRUN  = 1;
	localparam int unsigned IRQ_LINE_ERR = 2;
	localparam int unsigned IRQ_THR_EMPT = 3;

	// reset values
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [3:0] RST_IRQ  = 4'h0;

	// prescaler: last count of the divide-by-4 cycle
	localparam logic [1:0] PRESCALE_LAST = 2'h3;

	typedef struct packed {
		logic       brk;
		logic       frm;
		logic       par;
		logic [7:0] data;
	} ulm_rx_char_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} ulm_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} ulm_wb_rsp_t;

endpackage : ulm_pkg

// *** rtl/ulm_prescaler.sv ***
// input clock prescaler: tick every cycle, or every fourth cycle when divide-by-4 is chosen
// assumes the baud generator counts only on tick
`timescale 1ns/1ps
module ulm_prescaler (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// control
	input  wire logic div4_in,
	output logic      tick_out
);
	import ulm_pkg::*;

	typedef struct packed {
		logic [1:0] cnt;
		logic       tick;
	} ulm_pre_st_t;

	ulm_pre_st_t s_q;
	ulm_pre_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (div4_in) begin
			s_d.cnt  = s_q.cnt + 2'h1;
			s_d.tick = (s_q.cnt == PRESCALE_LAST);
		end else begin
			s_d.cnt  = 2'h0;
			s_d.tick = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_out = s_q.tick;

endmodule : ulm_prescaler

// *** rtl/ulm_top.sv ***
// line status, modem control and fifo front end of one serial channel, wishbone slave
// assumes a receiver and transmitter on CLK_IN; modem and rx pins are asynchronous
`timescale 1ns/1ps

// Behaviour
// - line status bit 7 set while any flagged character sits in rx fifo.
// - line status bit 6 is one only when holding and shift stages empty.
// - line status bit 5 is one when holding stage empty; host may write 64.
// - bit 4 flags break after a full low frame; that character is stored as 00.
// - bit 3 shows framing error of the character at the read position.
// - bit 2 shows parity error of the character at the read position.
// - bit 1 set when a character arrives with no room to store it.
// - bit 0 is one whenever the rx fifo holds at least one character.
// - break, framing, parity stored per entry; line status read shows head flags.
// - line status read leaves pointer; only rx holding read advances it.
// - modem control bit 7 selects clock divide by one or four.
// - modem control bit 6 opens flow threshold and trigger level registers.
// - modem control bit 5 lets any received character release a flow stop.
// - modem control bits 7 to 5 writable only with feature write enable set.
// - bit 4 loops control bits into modem status and tx into rx.
module ulm_top (
	// clock and reset
	input  wire logic                  CLK_IN,
	input  wire logic                  SRST_IN,
	// wishbone slave
	input  wire ulm_pkg::ulm_wb_req_t  WB_REQ_IN,
	output ulm_pkg::ulm_wb_rsp_t       WB_RSP_OUT,
	output logic                       IRQ_OUT,
	// receiver side
	input  wire logic                  RX_VALID_IN,
	input  wire ulm_pkg::ulm_rx_char_t RX_CHAR_IN,
	output logic                       SER_RX_OUT,
	output logic                       FLOW_RESUME_OUT,
	// transmitter side
	output logic [7:0]                 TX_DATA_OUT,
	output logic                       TX_VALID_OUT,
	input  wire logic                  TX_TAKE_IN,
	input  wire logic                  TX_SHIFT_EMPTY_IN,
	input  wire logic                  TX_SER_IN,
	output logic                       SER_TX_OUT,
	// baud prescaler
	output logic                       PRESCALE_TICK_OUT,
	// flow control thresholds
	output logic [7:0]                 FLOW_THRESH_OUT,
	output logic [7:0]                 TRIG_LEVEL_OUT,
	// pins
	input  wire logic                  RX_PIN_IN,
	input  wire logic                  CTS_N_IN,
	input  wire logic                  DSR_N_IN,
	input  wire logic                  RI_N_IN,
	input  wire logic                  CD_N_IN,
	output logic                       RTS_N_OUT,
	output logic                       DTR_N_OUT
);
	import ulm_pkg::*;

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdat;
		logic [7:0]        mctl;
		logic [7:0]        efeat;
		logic [7:0]        thresh;
		logic [7:0]        trig;
		logic [3:0]        irq_st;
		logic [3:0]        irq_mask;
		logic              irq;
		logic              overrun;
		logic [CNT_W-1:0]  err_cnt;
		logic [7:0]        tx_data;
		logic              tx_valid;
		logic              thre_prev;
		logic [4:0]        sync1;
		logic [4:0]        sync2;
		logic              ser_rx;
		logic              ser_tx;
		logic              resume;
		logic              rts_n;
		logic              dtr_n;
	} ulm_top_st_t;

	ulm_top_st_t  s_q;
	ulm_top_st_t  s_d;

	ulm_rx_char_t rx_push_char;
	ulm_rx_char_t rx_head;
	logic         rx_push;
	logic         rx_pop;
	logic         rx_empty;
	logic         rx_full;
	logic [7:0]   tx_head;
	logic         tx_push;
	logic         tx_pop;
	logic         tx_empty;
	logic         tx_full;
	logic         access;
	logic         rd_acc;
	logic         wr_acc;
	logic         thre;
	logic         temt;
	logic         loop_en;
	logic [7:0]   ls_word;
	logic [7:0]   ms_word;
	logic [3:0]   irq_ev;
	logic [3:0]   irq_clr;
	logic         push_flag;
	logic         pop_flag;

	// address match against one register offset
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction : hit

	ulm_fifo #(
		.W ($bits(ulm_rx_char_t))
	) u_rx_fifo (
		.clk_in       (CLK_IN),
		.srst_in      (SRST_IN),
		.push_in      (rx_push),
		.push_data_in (rx_push_char),
		.pop_in       (rx_pop),
		.head_out     (rx_head),
		.empty_out    (rx_empty),
		.full_out     (rx_full)
	);

	ulm_fifo #(
		.W (8)
	) u_tx_fifo (
		.clk_in       (CLK_IN),
		.srst_in      (SRST_IN),
		.push_in      (tx_push),
		.push_data_in (WB_REQ_IN.dat[7:0]),
		.pop_in       (tx_pop),
		.head_out     (tx_head),
		.empty_out    (tx_empty),
		.full_out     (tx_full)
	);

	ulm_prescaler u_prescaler (
		.clk_in   (CLK_IN),
		.srst_in  (SRST_IN),
		.div4_in  (s_q.mctl[MC_CLK_DIV4]),
		.tick_out (PRESCALE_TICK_OUT)
	);

	always_comb begin
		s_d     = s_q;
		access  = WB_REQ_IN.cyc && WB_REQ_IN.stb && !s_q.ack;
		rd_acc  = access && !WB_REQ_IN.we;
		wr_acc  = access && WB_REQ_IN.we && WB_REQ_IN.sel[0];
		loop_en = s_q.mctl[MC_LOOP];
		irq_clr = 4'h0;

		rx_push_char = RX_CHAR_IN;
		if (RX_CHAR_IN.brk) begin
			rx_push_char.data = 8'h00;
		end
		rx_push = RX_VALID_IN && !rx_full;

		rx_pop = rd_acc && hit(WB_REQ_IN.adr, OFS_HOLDING) && !rx_empty;

		// host fills tx fifo through the holding register
		tx_push = wr_acc && hit(WB_REQ_IN.adr, OFS_HOLDING) && !tx_full;

		// tx staging register feeding the transmitter
		tx_pop = (!s_q.tx_valid || TX_TAKE_IN) && !tx_empty;
		if (tx_pop) begin
			s_d.tx_data  = tx_head;
			s_d.tx_valid = 1'b1;
		end else if (TX_TAKE_IN) begin
			s_d.tx_valid = 1'b0;
		end

		// count flagged entries in rx fifo
		push_flag   = rx_push && (rx_push_char.brk || rx_push_char.frm || rx_push_char.par);
		pop_flag    = rx_pop && (rx_head.brk || rx_head.frm || rx_head.par);
		s_d.err_cnt = s_q.err_cnt + CNT_W'(push_flag) - CNT_W'(pop_flag);

		thre = tx_empty && !s_q.tx_valid;
		temt = thre && TX_SHIFT_EMPTY_IN;

		ls_word                = RST_REG8;
		ls_word[LS_FIFO_ERR]   = (s_q.err_cnt != '0);
		ls_word[LS_TX_EMPTY]   = temt;
		ls_word[LS_HOLD_EMPTY] = thre;
		// head flags onto bits 4 to 2
		ls_word[LS_BREAK]      = !rx_empty && rx_head.brk;
		ls_word[LS_FRAME]      = !rx_empty && rx_head.frm;
		ls_word[LS_PARITY]     = !rx_empty && rx_head.par;
		ls_word[LS_OVERRUN]    = s_q.overrun;
		ls_word[LS_DATA_READY] = !rx_empty;

		// loop control bits into modem status
		if (loop_en) begin
			ms_word = {s_q.mctl[MC_OUT2], s_q.mctl[MC_OUT1], s_q.mctl[MC_DTR], s_q.mctl[MC_RTS], 4'h0};
		end else begin
			ms_word = {~s_q.sync2[3], ~s_q.sync2[2], ~s_q.sync2[1], ~s_q.sync2[0], 4'h0};
		end

		// overrun set wins over read clear
		if (RX_VALID_IN && rx_full) begin
			s_d.overrun = 1'b1;
		end else if (rd_acc && hit(WB_REQ_IN.adr, OFS_LINE_STATUS)) begin
			s_d.overrun = 1'b0;
		end

		// register writes
		if (wr_acc) begin
			if (hit(WB_REQ_IN.adr, OFS_MODEM_CTRL)) begin
				if (s_q.efeat[EF_WRITE_EN]) begin
					s_d.mctl = WB_REQ_IN.dat[7:0];
				end else begin
					s_d.mctl = (s_q.mctl & MC_PROT_MASK) | (WB_REQ_IN.dat[7:0] & ~MC_PROT_MASK);
				end
			end
			if (hit(WB_REQ_IN.adr, OFS_ENH_FEATURE)) begin
				s_d.efeat = WB_REQ_IN.dat[7:0];
			end
			// threshold registers reachable only when enabled
			if (hit(WB_REQ_IN.adr, OFS_FLOW_THRESH) && s_q.mctl[MC_THRESH_EN]) begin
				s_d.thresh = WB_REQ_IN.dat[7:0];
			end
			if (hit(WB_REQ_IN.adr, OFS_TRIG_LEVEL) && s_q.mctl[MC_THRESH_EN]) begin
				s_d.trig = WB_REQ_IN.dat[7:0];
			end
			if (hit(WB_REQ_IN.adr, OFS_IRQ_STATUS)) begin
				irq_clr = WB_REQ_IN.dat[3:0];
			end
			if (hit(WB_REQ_IN.adr, OFS_IRQ_MASK)) begin
				s_d.irq_mask = WB_REQ_IN.dat[3:0];
			end
		end

		// register reads, registered with ack
		s_d.ack  = access;
		s_d.rdat = 32'h0000_0000;
		if (rd_acc) begin
			if (hit(WB_REQ_IN.adr, OFS_HOLDING)) begin
				s_d.rdat[7:0] = rx_empty ? 8'h00 : rx_head.data;
			end else if (hit(WB_REQ_IN.adr, OFS_LINE_STATUS)) begin
				s_d.rdat[7:0] = ls_word;
			end else if (hit(WB_REQ_IN.adr, OFS_MODEM_CTRL)) begin
				s_d.rdat[7:0] = s_q.mctl;
			end else if (hit(WB_REQ_IN.adr, OFS_ENH_FEATURE)) begin
				s_d.rdat[7:0] = s_q.efeat;
			end else if (hit(WB_REQ_IN.adr, OFS_MODEM_STATUS)) begin
				s_d.rdat[7:0] = ms_word;
			end else if (hit(WB_REQ_IN.adr, OFS_FLOW_THRESH) && s_q.mctl[MC_THRESH_EN]) begin
				s_d.rdat[7:0] = s_q.thresh;
			end else if (hit(WB_REQ_IN.adr, OFS_TRIG_LEVEL) && s_q.mctl[MC_THRESH_EN]) begin
				s_d.rdat[7:0] = s_q.trig;
			end else if (hit(WB_REQ_IN.adr, OFS_IRQ_STATUS)) begin
				s_d.rdat[3:0] = s_q.irq_st;
			end else if (hit(WB_REQ_IN.adr, OFS_IRQ_MASK)) begin
				s_d.rdat[3:0] = s_q.irq_mask;
			end
		end

		// sticky events, set wins over clear
		irq_ev               = 4'h0;
		irq_ev[IRQ_RX_DATA]  = rx_push;
		irq_ev[IRQ_OVERRUN]  = RX_VALID_IN && rx_full;
		irq_ev[IRQ_LINE_ERR] = push_flag;
		irq_ev[IRQ_THR_EMPT] = thre && !s_q.thre_prev;
		s_d.thre_prev        = thre;
		s_d.irq_st           = (s_q.irq_st & ~irq_clr) | irq_ev;
		s_d.irq              = |(s_d.irq_st & s_q.irq_mask);

		// pin synchronisers: cts, dsr, ri, cd, rx
		s_d.sync1 = {RX_PIN_IN, CD_N_IN, RI_N_IN, DSR_N_IN, CTS_N_IN};
		s_d.sync2 = s_q.sync1;

		// internal tx to rx loop, line held idle
		s_d.ser_rx = loop_en ? TX_SER_IN : s_q.sync2[4];
		s_d.ser_tx = loop_en ? 1'b1 : TX_SER_IN;
		s_d.rts_n  = loop_en ? 1'b1 : ~s_q.mctl[MC_RTS];
		s_d.dtr_n  = loop_en ? 1'b1 : ~s_q.mctl[MC_DTR];

		// any received character releases a flow stop
		s_d.resume = s_q.mctl[MC_XON_ANY] && RX_VALID_IN;
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			s_q           <= '0;
			s_q.mctl      <= RST_REG8;
			s_q.efeat     <= RST_REG8;
			s_q.irq_st    <= RST_IRQ;
			s_q.irq_mask  <= RST_IRQ;
			s_q.sync1     <= 5'h1F;
			s_q.sync2     <= 5'h1F;
			s_q.ser_rx    <= 1'b1;
			s_q.ser_tx    <= 1'b1;
			s_q.rts_n     <= 1'b1;
			s_q.dtr_n     <= 1'b1;
			s_q.thre_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign WB_RSP_OUT.ack = s_q.ack;
	assign WB_RSP_OUT.dat = s_q.rdat;
	assign IRQ_OUT         = s_q.irq;
	assign SER_RX_OUT      = s_q.ser_rx;
	assign SER_TX_OUT      = s_q.ser_tx;
	assign FLOW_RESUME_OUT = s_q.resume;
	assign TX_DATA_OUT     = s_q.tx_data;
	assign TX_VALID_OUT    = s_q.tx_valid;
	assign FLOW_THRESH_OUT = s_q.thresh;
	assign TRIG_LEVEL_OUT  = s_q.trig;
	assign RTS_N_OUT       = s_q.rts_n;
	assign DTR_N_OUT       = s_q.dtr_n;

endmodule : ulm_top

// *** verif/ulm_checker.sv ***
// checker: bus handshake, status read fields, tx staging, prescaler, resume pulse
// assumes only the top's ports, one clock domain
`timescale 1ns/1ps
module ulm_checker (
	input wire logic                 CLK_IN,
	input wire logic                 SRST_IN,
	input wire ulm_pkg::ulm_wb_req_t WB_REQ_IN,
	input wire ulm_pkg::ulm_wb_rsp_t WB_RSP_OUT,
	input wire logic                 RX_VALID_IN,
	input wire logic                 FLOW_RESUME_OUT,
	input wire logic                 PRESCALE_TICK_OUT,
	input wire logic                 TX_VALID_OUT,
	input wire logic [7:0]           TX_DATA_OUT,
	input wire logic                 TX_TAKE_IN,
	input wire logic [7:0]           FLOW_THRESH_OUT
);
	import ulm_pkg::*;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	logic req, ack, rd, ls_rd;
	assign req = WB_REQ_IN.cyc && WB_REQ_IN.stb;
	assign ack = WB_RSP_OUT.ack;
	assign rd = ack && !WB_REQ_IN.we;
	assign ls_rd = rd && WB_REQ_IN.adr == OFS_LINE_STATUS;
	chk_ack_one: assert property (ack |=> !ack) else $error("ack held too long");
	chk_ack_time: assert property ($rose(req) |=> ack) else $error("ack late");
	chk_ack_idle: assert property (!req |=> !ack) else $error("ack without request");
	chk_flag_data:
	assert property (ls_rd && WB_RSP_OUT.dat[4:2] != 3'h0 |-> WB_RSP_OUT.dat[7] && WB_RSP_OUT.dat[0])
		else $error("head flag without data or summary");
	chk_thre_staged:
	assert property (ls_rd && $past(TX_VALID_OUT) |-> !WB_RSP_OUT.dat[5]) else $error("holding empty while staged");
	chk_temt_thre:
	assert property (ls_rd && WB_RSP_OUT.dat[6] |-> WB_RSP_OUT.dat[5]) else $error("tx empty without holding empty");
	chk_tx_hold:
	assert property (TX_VALID_OUT && !TX_TAKE_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
		else $error("staged byte lost");
	chk_tick_div:
	assert property ($fell(PRESCALE_TICK_OUT) |=> !PRESCALE_TICK_OUT ##1 !PRESCALE_TICK_OUT)
		else $error("prescaler gap short");
	chk_resume_cause:
	assert property (FLOW_RESUME_OUT |-> $past(RX_VALID_IN)) else $error("resume without character");
	chk_thresh_read:
	assert property (rd && WB_REQ_IN.adr == OFS_FLOW_THRESH |-> WB_RSP_OUT.dat[7:0] == 8'h00
		|| WB_RSP_OUT.dat[7:0] == FLOW_THRESH_OUT) else $error("threshold read wrong");
	cov_err: cover property (ls_rd && WB_RSP_OUT.dat[7]);
	cov_resume: cover property (FLOW_RESUME_OUT);
	cov_take: cover property (TX_TAKE_IN && TX_VALID_OUT);
endmodule : ulm_checker

bind ulm_top ulm_checker u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .WB_REQ_IN(WB_REQ_IN),
	.WB_RSP_OUT(WB_RSP_OUT), .RX_VALID_IN(RX_VALID_IN), .FLOW_RESUME_OUT(FLOW_RESUME_OUT),
	.PRESCALE_TICK_OUT(PRESCALE_TICK_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_DATA_OUT(TX_DATA_OUT),
	.TX_TAKE_IN(TX_TAKE_IN), .FLOW_THRESH_OUT(FLOW_THRESH_OUT));

// *** verif/ulm_top_tb.sv ***
// testbench: register accesses over wishbone, rx pushes, tx drain through the model
// assumes the checker is bound to the top
`timescale 1ns/1ps
module ulm_top_tb;
	import ulm_pkg::*;
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         rx_valid = 1'b0;
	logic         stall = 1'b1;
	ulm_wb_req_t  req = '0;
	ulm_wb_rsp_t  rsp;
	ulm_rx_char_t rx_char = '0;
	logic         rx_pin = 1'b1;
	logic         irq, resume, tick, tx_valid, take, shift_empty, ser_tx, ser_rx, ser_line, rts_n, dtr_n;
	logic [7:0]   tx_data, thresh, trig, rd;
	logic [7:0]   ls_e [0:3] = '{8'hE1, 8'hF1, 8'hE9, 8'hE5};
	logic [7:0]   dt_e [0:3] = '{8'h41, 8'h00, 8'h42, 8'h43};
	int           errors = 0;
	int           checks = 0;
	always #2.5 clk = ~clk;
	ulm_top DUT (.CLK_IN(clk), .SRST_IN(srst), .WB_REQ_IN(req), .WB_RSP_OUT(rsp), .IRQ_OUT(irq),
		.RX_VALID_IN(rx_valid), .RX_CHAR_IN(rx_char), .SER_RX_OUT(ser_rx), .FLOW_RESUME_OUT(resume),
		.TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_TAKE_IN(take), .TX_SHIFT_EMPTY_IN(shift_empty),
		.TX_SER_IN(ser_tx), .SER_TX_OUT(ser_line), .PRESCALE_TICK_OUT(tick), .FLOW_THRESH_OUT(thresh),
		.TRIG_LEVEL_OUT(trig), .RX_PIN_IN(rx_pin), .CTS_N_IN(1'b1), .DSR_N_IN(1'b1), .RI_N_IN(1'b1),
		.CD_N_IN(1'b1), .RTS_N_OUT(rts_n), .DTR_N_OUT(dtr_n));
	ulm_tx_model u_tx (.clk_in(clk), .srst_in(srst), .valid_in(tx_valid), .data_in(tx_data),
		.stall_in(stall), .take_out(take), .shift_empty_out(shift_empty), .ser_out(ser_tx));
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8
	task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
		int n;
		n = 0;
		req <= '{1'b1, 1'b1, we, 4'hF, adr, {24'h0, wd}};
		do begin
			@(posedge clk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 20);
		if (rsp.ack !== 1'b1) begin
			errors++;
			print_verdict();
		end else begin
			rd = rsp.dat[7:0];
			req <= '0;
			@(posedge clk);
		end
	endtask : wb
	task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
		wb(1'b0, adr, 8'h00);
		cmp8(rd, exp);
	endtask : rchk
	task automatic push(input logic [10:0] c);
		rx_valid <= 1'b1;
		rx_char <= c;
		@(posedge clk);
		rx_valid <= 1'b0;
		@(posedge clk);
	endtask : push
	task automatic ticks(input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		repeat (8) begin
			@(posedge clk);
			n = n + {7'h0, tick};
		end
		cmp8(n, exp);
	endtask : ticks
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rchk(OFS_LINE_STATUS, 8'h60);
		rchk(OFS_MODEM_CTRL, 8'h00);
		wb(1'b1, 8'h24, 8'h55);
		rchk(8'h24, 8'h00);
		rx_pin <= 1'b0;
		ticks(8'h08);
		cmp8({7'h0, ser_rx}, 8'h00);
		wb(1'b1, OFS_MODEM_CTRL, 8'hFF);
		rchk(OFS_MODEM_CTRL, 8'h1F);
		rchk(OFS_MODEM_STATUS, 8'hF0);
		cmp8({4'h0, rts_n, dtr_n, ser_rx, ser_line}, 8'h0F);
		wb(1'b1, OFS_ENH_FEATURE, 8'h10);
		wb(1'b1, OFS_MODEM_CTRL, 8'hE3);
		rchk(OFS_MODEM_CTRL, 8'hE3);
		cmp8({4'h0, rts_n, dtr_n, ser_rx, ser_line}, 8'h01);
		ticks(8'h02);
		wb(1'b1, OFS_FLOW_THRESH, 8'h5A);
		rchk(OFS_FLOW_THRESH, 8'h5A);
		cmp8(thresh, 8'h5A);
		wb(1'b1, OFS_TRIG_LEVEL, 8'h3C);
		rchk(OFS_TRIG_LEVEL, 8'h3C);
		cmp8(trig, 8'h3C);
		wb(1'b1, OFS_MODEM_CTRL, 8'hA0);
		rchk(OFS_FLOW_THRESH, 8'h00);
		push(11'h041);
		cmp8({7'h0, resume}, 8'h01);
		push(11'h477);
		push(11'h242);
		push(11'h143);
		for (int i = 0; i < 4; i++) begin
			rchk(OFS_LINE_STATUS, ls_e[i]);
			rchk(OFS_LINE_STATUS, ls_e[i]);
			rchk(OFS_HOLDING, dt_e[i]);
		end
		rchk(OFS_LINE_STATUS, 8'h60);
		repeat (65) push(11'h0AA);
		rchk(OFS_LINE_STATUS, 8'h63);
		rchk(OFS_LINE_STATUS, 8'h61);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rchk(OFS_LINE_STATUS, 8'h60);
		push(11'h055);
		cmp8({7'h0, irq}, 8'h00);
		wb(1'b1, OFS_IRQ_MASK, 8'h01);
		wb(1'b0, OFS_IRQ_STATUS, 8'h00);
		cmp8(rd & 8'h07, 8'h01);
		cmp8({7'h0, irq}, 8'h01);
		wb(1'b1, OFS_IRQ_STATUS, 8'h01);
		cmp8({7'h0, irq}, 8'h00);
		wb(1'b1, OFS_HOLDING, 8'hA1);
		wb(1'b1, OFS_HOLDING, 8'hA2);
		wb(1'b1, OFS_HOLDING, 8'hA3);
		rchk(OFS_LINE_STATUS, 8'h01);
		stall <= 1'b0;
		for (int n = 0; n < 200 && !(u_tx.n_q == 3 && shift_empty); n++) begin
			@(posedge clk);
		end
		cmp8({7'h0, u_tx.n_q == 3 && shift_empty}, 8'h01);
		rchk(OFS_LINE_STATUS, 8'h61);
		for (int i = 0; i < 3; i++) begin
			cmp8(u_tx.got_q[i], 8'hA1 + 8'(i));
		end
		print_verdict();
	end
endmodule : ulm_top_tb

// *** verif/ulm_tx_model.sv ***
// transmitter stand-in: takes staged bytes, shifts a few cycles, records them
// assumes one clock shared with the block
`timescale 1ns/1ps
module ulm_tx_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	// staged byte
	input  wire logic       valid_in,
	input  wire logic [7:0] data_in,
	input  wire logic       stall_in,
	output logic            take_out,
	// line side
	output logic            shift_empty_out,
	output logic            ser_out
);
	logic [2:0] cnt_q;
	logic [7:0] got_q [0:7];
	int         n_q;
	assign take_out = valid_in && !stall_in && cnt_q == 3'h0;
	assign shift_empty_out = cnt_q == 3'h0;
	assign ser_out = shift_empty_out | cnt_q[0];
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_q <= 3'h0;
			n_q <= 0;
		end else if (take_out) begin
			cnt_q <= 3'h4;
			got_q[n_q[2:0]] <= data_in;
			n_q <= n_q + 1;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end
endmodule : ulm_tx_model
